// ### hw/cms_map.vh
// Constants for the CPU mode and segment protection block.
// Assumes a 125 MHz clock and an Avalon-MM register bus with word addresses in bytes.
`ifndef CMS_MAP_VH
`define CMS_MAP_VH

// ------------------------------------------------------------
// Modes
// ------------------------------------------------------------
`define CMS_MODE_BOOT 3'h0
`define CMS_MODE_TEST 3'h1
`define CMS_MODE_FW 3'h2
`define CMS_MODE_SYS 3'h3
`define CMS_MODE_USER 3'h4

// ------------------------------------------------------------
// Address map of the virtual space (16-bit)
// ------------------------------------------------------------
`define CMS_RAM_BASE 16'h0000
`define CMS_ROM_BASE 16'h4000
`define CMS_NVM_BASE 16'h8000
`define CMS_SFR_BASE 16'hF000
`define CMS_NVM_RSVD 16'hEF00
`define CMS_NVM_RSVD_BYTES 256
`define CMS_TGT_RAM 2'h0
`define CMS_TGT_ROM 2'h1
`define CMS_TGT_NVM 2'h2
`define CMS_TGT_SFR 2'h3

// ------------------------------------------------------------
// Exception causes and vectors
// ------------------------------------------------------------
`define CMS_EXC_BKPT 0
`define CMS_EXC_FAULT 1
`define CMS_EXC_ILL 2
`define CMS_EXC_STACK 3
`define CMS_EXC_SYSC 4
`define CMS_EXC_RETURN_FROM_INTERRUPT_INSTR 5
`define CMS_EXC_VIOL 6
`define CMS_EXC_COLL 7
`define CMS_VEC_BASE 16'h0100
`define CMS_VEC_STEP 4

// ------------------------------------------------------------
// Registers (byte offsets)
// ------------------------------------------------------------
`define CMS_REG_MODE 8'h00
`define CMS_REG_STATUS 8'h04
`define CMS_REG_MASK 8'h08
`define CMS_REG_LOCK 8'h0C
`define CMS_REG_SEG_SEL 8'h10
`define CMS_REG_SEG_BASE 8'h14
`define CMS_REG_SEG_SIZE 8'h18
`define CMS_REG_SEG_CTRL 8'h1C
`define CMS_REG_FAULT 8'h20
`define CMS_SEGS 64
`define CMS_SEG_EN 0
`define CMS_SEG_R 1
`define CMS_SEG_W 2
`define CMS_SEG_X 3
`define CMS_SEG_SFR_LSB 8
`define CMS_SFR_GROUPS 8
`define CMS_LOCK_KEY 32'hA5A5_5A5A
`define CMS_RESET_STATUS 8'h00
`define CMS_RESET_MASK 8'h00

`endif

// ### hw/cms_seg_check.v
// Segment lookup: compares one user access against all 64 descriptors.
// Assumes descriptors are flattened by the parent and stable in the cycle.
`timescale 1ns/1ps
`include "cms_map.vh"

module cms_seg_check (
  input wire [16*64-1:0] base_flat,
  input wire [16*64-1:0] size_flat,
  input wire [16*64-1:0] ctrl_flat,
  input wire [15:0] addr,
  input wire is_rd,
  input wire is_wr,
  input wire is_fetch,
  input wire [2:0] sfr_group,
  input wire is_sfr,
  input wire [15:0] pc,
  output wire allow,
  output wire collide
);
  wire [63:0] hit;
  wire [63:0] ok;
  wire [63:0] code_seg;
  wire [63:0] sfr_ok;

  // ----------------------------------------------------------
  // Per-segment match and rights
  // ----------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `CMS_SEGS; g = g + 1) begin : seg
      wire [15:0] b = base_flat[g*16 +: 16];
      wire [15:0] s = size_flat[g*16 +: 16];
      wire [15:0] c = ctrl_flat[g*16 +: 16];
      wire [16:0] lim = {1'b0, b} + {1'b0, s};
      assign hit[g] = c[`CMS_SEG_EN] && ({1'b0, addr} >= {1'b0, b}) &&
        ({1'b0, addr} < lim);
      assign ok[g] = hit[g] && (!is_rd || c[`CMS_SEG_R]) && (!is_wr || c[`CMS_SEG_W]) &&
        (!is_fetch || c[`CMS_SEG_X]);
      assign code_seg[g] = c[`CMS_SEG_EN] && ({1'b0, pc} >= {1'b0, b}) &&
        ({1'b0, pc} < lim);
      assign sfr_ok[g] = code_seg[g] && c[`CMS_SEG_SFR_LSB + sfr_group];
    end
  endgenerate

  // Outside the SFR space, overlapping segments of which some grant and some refuse this access count as a collision
  assign collide = !is_sfr && (hit != 64'h0) && (ok != 64'h0) && (ok != hit);
  assign allow = is_sfr ? (sfr_ok != 64'h0) : ((ok != 64'h0) && !collide);
endmodule // cms_seg_check

// ### hw/cms_mode_mmu.v
// CPU mode tracker, address translation and exception unit.
// Assumes a CPU core on the same clock and Avalon-MM register access.
// The test lock has no reset: only power-up clears it.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "cms_map.vh"

module cms_mode_mmu (
  input wire clock,
  input wire reset,
  // Avalon-MM slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output wire irq,
  // CPU access
  input wire cpu_req,
  input wire cpu_we,
  input wire cpu_fetch,
  input wire [15:0] cpu_addr,
  input wire [15:0] cpu_pc,
  input wire boot_done,
  input wire fw_enter,
  input wire fw_exit,
  input wire test_enter,
  input wire test_exit,
  input wire sys_to_user,
  input wire [4:0] cpu_exc_src,
  input wire return_from_interrupt_instr_exec,
  output reg mem_req,
  output reg [1:0] mem_target,
  output reg [15:0] mem_phys,
  output reg mem_we,
  output reg exc_take,
  output reg [15:0] exc_vector,
  output reg [2:0] cpu_mode,
  output wire nvm_rsvd_hit
);
  reg [15:0] seg_base [0:63];
  reg [15:0] seg_size [0:63];
  reg [15:0] seg_ctrl [0:63];
  reg [7:0] status_reg;
  reg [7:0] mask_reg;
  reg test_dead_reg = 1'b0; // Power-up value only
  reg [5:0] sel_reg;
  reg [15:0] fault_addr_reg;
  reg ack_reg;
  reg [7:0] exc_now;
  reg [2:0] exc_idx;
  reg [1:0] target;
  reg [15:0] phys;
  wire [16*64-1:0] base_flat;
  wire [16*64-1:0] size_flat;
  wire [16*64-1:0] ctrl_flat;
  wire seg_allow;
  wire seg_collide;
  wire is_sfr;
  wire user_acc;
  wire block_acc;
  wire sys_cfg;
  wire bus_req;
  wire cfg_wr;
  wire stat_rd;
  wire mask_wr;
  wire sel_wr;
  wire lock_wr;
  reg [2:0] mode_next;
  integer i;
  integer k;

  // ----------------------------------------------------------
  // Flatten descriptor table for the checker
  // ----------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `CMS_SEGS; g = g + 1) begin : flat
      assign base_flat[g*16 +: 16] = seg_base[g];
      assign size_flat[g*16 +: 16] = seg_size[g];
      assign ctrl_flat[g*16 +: 16] = seg_ctrl[g];
    end
  endgenerate

  assign is_sfr = cpu_addr >= `CMS_SFR_BASE;
  assign user_acc = cpu_req && (cpu_mode == `CMS_MODE_USER);

  cms_seg_check u_check (
    .base_flat(base_flat),
    .size_flat(size_flat),
    .ctrl_flat(ctrl_flat),
    .addr(cpu_addr),
    .is_rd(!cpu_we && !cpu_fetch),
    .is_wr(cpu_we),
    .is_fetch(cpu_fetch),
    .sfr_group(cpu_addr[6:4]),
    .is_sfr(is_sfr),
    .pc(cpu_pc),
    .allow(seg_allow),
    .collide(seg_collide)
  );

  // ----------------------------------------------------------
  // Fixed partitioning of the virtual space
  // ----------------------------------------------------------
  always @* begin
    if (is_sfr) begin
      target = `CMS_TGT_SFR;
      phys = cpu_addr - `CMS_SFR_BASE;
    end else if (cpu_addr >= `CMS_NVM_BASE) begin
      target = `CMS_TGT_NVM;
      phys = cpu_addr - `CMS_NVM_BASE;
    end else if (cpu_addr >= `CMS_ROM_BASE) begin
      target = `CMS_TGT_ROM;
      phys = cpu_addr - `CMS_ROM_BASE;
    end else begin
      target = `CMS_TGT_RAM;
      phys = cpu_addr - `CMS_RAM_BASE;
    end
  end

  // Reserved top of NVM: only the super modes and system may touch it
  assign nvm_rsvd_hit = cpu_req && !is_sfr && (cpu_addr >= `CMS_NVM_RSVD);

  // User access blocked if no segment grants it; system is unchecked
  assign block_acc = user_acc && (!seg_allow || nvm_rsvd_hit);

  // ----------------------------------------------------------
  // Exception collection
  // ----------------------------------------------------------
  always @* begin
    exc_now = {3'h0, cpu_exc_src};
    exc_now[`CMS_EXC_RETURN_FROM_INTERRUPT_INSTR] = return_from_interrupt_instr_exec && (cpu_mode == `CMS_MODE_USER);
    exc_now[`CMS_EXC_VIOL] = block_acc && !seg_collide;
    exc_now[`CMS_EXC_COLL] = user_acc && seg_collide;
  end

  // Lowest cause index wins the vector
  always @* begin
    exc_idx = 3'h0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (exc_now[i]) begin
        exc_idx = i[2:0];
      end
    end
  end

  // ----------------------------------------------------------
  // Mode machine: next mode
  // ----------------------------------------------------------
  // Exceptions override every requested mode change
  always @* begin
    mode_next = cpu_mode;
    if (exc_now != 8'h00) begin
      mode_next = `CMS_MODE_SYS;
    end else begin
      case (cpu_mode)
        `CMS_MODE_BOOT: begin
          if (test_enter && !test_dead_reg) begin
            mode_next = `CMS_MODE_TEST;
          end else if (boot_done) begin
            mode_next = `CMS_MODE_SYS;
          end
        end
        `CMS_MODE_TEST: begin
          if (test_exit || test_dead_reg) begin
            mode_next = `CMS_MODE_BOOT;
          end
        end
        `CMS_MODE_FW: begin
          if (fw_exit) begin
            mode_next = `CMS_MODE_SYS;
          end
        end
        `CMS_MODE_SYS: begin
          // Firmware only via the dedicated hardware entry
          if (fw_enter) begin
            mode_next = `CMS_MODE_FW;
          end else if (sys_to_user) begin
            mode_next = `CMS_MODE_USER;
          end
        end
        `CMS_MODE_USER: begin
          // Only an exception leaves user mode
          mode_next = `CMS_MODE_USER;
        end
        default: begin
          mode_next = `CMS_MODE_SYS;
        end
      endcase
    end
  end

  // Mode register; boot is the only reset state
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      cpu_mode <= `CMS_MODE_BOOT;
    end else begin
      cpu_mode <= mode_next;
    end
  end

  // ----------------------------------------------------------
  // Exception dispatch and blocked-access record
  // ----------------------------------------------------------
  // No mask applies to the jump itself
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      exc_take <= 1'b0;
      exc_vector <= 16'h0000;
    end else begin
      exc_take <= (exc_now != 8'h00);
      if (exc_now != 8'h00) begin
        exc_vector <= `CMS_VEC_BASE + {11'h0, exc_idx, 2'h0};
      end
    end
  end

  // Address of the last blocked user access
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      fault_addr_reg <= 16'h0000;
    end else if (block_acc) begin
      fault_addr_reg <= cpu_addr;
    end
  end

  // ----------------------------------------------------------
  // Translated request towards the memories
  // ----------------------------------------------------------
  // Blocked user accesses never reach a memory
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      mem_req <= 1'b0;
      mem_target <= 2'h0;
      mem_phys <= 16'h0000;
      mem_we <= 1'b0;
    end else begin
      mem_req <= cpu_req && !block_acc;
      mem_target <= target;
      mem_phys <= phys;
      mem_we <= cpu_req && cpu_we && !block_acc;
    end
  end

  // ----------------------------------------------------------
  // Register bus: one wait cycle per access
  // ----------------------------------------------------------
  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack_reg;
  assign sys_cfg = (cpu_mode == `CMS_MODE_SYS) || (cpu_mode == `CMS_MODE_BOOT);
  assign irq = (status_reg & mask_reg) != 8'h00;
  assign cfg_wr = avs_write && ack_reg && sys_cfg;
  assign stat_rd = avs_read && ack_reg && (avs_address == `CMS_REG_STATUS);

  // Decoded configuration strobes, all taken at the accepting edge
  assign mask_wr = cfg_wr && (avs_address == `CMS_REG_MASK);
  assign sel_wr = cfg_wr && (avs_address == `CMS_REG_SEG_SEL);
  assign lock_wr = cfg_wr && (avs_address == `CMS_REG_LOCK) && (avs_writedata == `CMS_LOCK_KEY);

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req && !ack_reg;
    end
  end

  // Read data mux
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_reg) begin
      case (avs_address)
        `CMS_REG_MODE: avs_readdata <= {29'h0, cpu_mode};
        `CMS_REG_STATUS: avs_readdata <= {24'h0, status_reg};
        `CMS_REG_MASK: avs_readdata <= {24'h0, mask_reg};
        `CMS_REG_LOCK: avs_readdata <= {31'h0, test_dead_reg};
        `CMS_REG_SEG_SEL: avs_readdata <= {26'h0, sel_reg};
        `CMS_REG_SEG_BASE: avs_readdata <= {16'h0, seg_base[sel_reg]};
        `CMS_REG_SEG_SIZE: avs_readdata <= {16'h0, seg_size[sel_reg]};
        `CMS_REG_SEG_CTRL: avs_readdata <= {16'h0, seg_ctrl[sel_reg]};
        `CMS_REG_FAULT: avs_readdata <= {16'h0, fault_addr_reg};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Status: sticky; a read clears only the bits it reported, set wins
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      status_reg <= `CMS_RESET_STATUS;
    end else if (stat_rd) begin
      status_reg <= (status_reg & ~avs_readdata[7:0]) | exc_now;
    end else begin
      status_reg <= status_reg | exc_now;
    end
  end

  // ----------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------
  // Interrupt mask
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      mask_reg <= `CMS_RESET_MASK;
    end else if (mask_wr) begin
      mask_reg <= avs_writedata[7:0];
    end
  end

  // Segment select
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      sel_reg <= 6'h00;
    end else if (sel_wr) begin
      sel_reg <= avs_writedata[5:0];
    end
  end

  // Test lock: no reset, so a reset never brings test mode back
  always @(posedge clock) begin
    if (lock_wr) begin
      test_dead_reg <= 1'b1;
    end
  end

  // Descriptor table: only system or boot code may rewrite it
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      for (k = 0; k < `CMS_SEGS; k = k + 1) begin
        seg_base[k] <= 16'h0000;
        seg_size[k] <= 16'h0000;
        seg_ctrl[k] <= 16'h0000;
      end
    end else if (cfg_wr) begin
      case (avs_address)
        `CMS_REG_SEG_BASE: seg_base[sel_reg] <= avs_writedata[15:0];
        `CMS_REG_SEG_SIZE: seg_size[sel_reg] <= avs_writedata[15:0];
        `CMS_REG_SEG_CTRL: seg_ctrl[sel_reg] <= avs_writedata[15:0];
        default: seg_base[sel_reg] <= seg_base[sel_reg];
      endcase
    end
  end
endmodule // cms_mode_mmu

// ### testbench/cms_mode_mmu_props.sv
// Checker for the mode and segment block, watching top-level ports only.
// Assumes one clock domain and the asynchronous active-high reset.
`timescale 1ns/1ps

module cms_mode_mmu_props (
  input wire clock,
  input wire reset,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire irq,
  input wire cpu_req,
  input wire [15:0] cpu_addr,
  input wire [4:0] cpu_exc_src,
  input wire return_from_interrupt_instr_exec,
  input wire mem_req,
  input wire [1:0] mem_target,
  input wire exc_take,
  input wire [15:0] exc_vector,
  input wire [2:0] cpu_mode,
  input wire nvm_rsvd_hit
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_mode_legal: assert property (cpu_mode <= 3'h4)
    else $error("mode code out of range");
  a_exc_system: assert property (exc_take |-> cpu_mode == 3'h3)
    else $error("exception left mode not system");
  a_source_taken: assert property (|cpu_exc_src |=> exc_take &&
    exc_vector[15:5] == 11'h008 && exc_vector[1:0] == 2'h0)
    else $error("exception source not taken");
  a_user_return_from_interrupt_instr: assert property (return_from_interrupt_instr_exec && cpu_mode == 3'h4 && cpu_exc_src == 5'h00 |=>
    exc_take && exc_vector == 16'h0114)
    else $error("user return not trapped");
  a_system_free: assert property (cpu_req && cpu_mode == 3'h3 && cpu_exc_src == 5'h00 &&
    !return_from_interrupt_instr_exec |=> mem_req && !exc_take)
    else $error("system access blocked");
  a_boot_once: assert property (cpu_mode != 3'h0 && cpu_mode != 3'h1 |=>
    cpu_mode != 3'h0)
    else $error("boot mode re-entered");
  a_user_exit: assert property (cpu_mode == 3'h4 |=>
    cpu_mode == 3'h4 || (exc_take && cpu_mode == 3'h3))
    else $error("user mode left without exception");
  a_rsvd_map: assert property (cpu_req |-> nvm_rsvd_hit == (cpu_addr[15:8] == 8'hEF))
    else $error("reserved area decode wrong");
  a_rsvd_user: assert property (cpu_req && cpu_mode == 3'h4 && nvm_rsvd_hit |=>
    !mem_req && exc_take)
    else $error("user reached reserved area");
  a_block_raise: assert property (cpu_req |=> mem_req || exc_take)
    else $error("access neither passed nor trapped");
  a_wait_first: assert property ($rose(avs_read | avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer timing wrong");

  c_exc: cover property (exc_take && exc_vector == 16'h0118);
  c_sfr: cover property (mem_req && mem_target == 2'h3);
  c_irq: cover property (irq);
  c_user: cover property (cpu_mode == 3'h4 && cpu_req);
endmodule // cms_mode_mmu_props

bind cms_mode_mmu cms_mode_mmu_props i_props (.clock(clock), .reset(reset), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .irq(irq), .cpu_req(cpu_req),
  .cpu_addr(cpu_addr), .cpu_exc_src(cpu_exc_src), .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec), .mem_req(mem_req),
  .mem_target(mem_target), .exc_take(exc_take), .exc_vector(exc_vector), .cpu_mode(cpu_mode),
  .nvm_rsvd_hit(nvm_rsvd_hit));

// ### testbench/cms_cpu_model.sv
// CPU core model: one-cycle virtual accesses and mode or exception strobes.
// Assumes the block samples every input on the rising clock edge.
`timescale 1ns/1ps

module cms_cpu_model (
  input wire logic clock,
  output logic cpu_req,
  output logic cpu_we,
  output logic cpu_fetch,
  output logic [15:0] cpu_addr,
  output logic [15:0] cpu_pc,
  output logic [5:0] mode_pulse,
  output logic [4:0] cpu_exc_src,
  output logic return_from_interrupt_instr_exec
);
  // Idle state at time zero
  initial begin
    {cpu_req, cpu_we, cpu_fetch, return_from_interrupt_instr_exec} = 4'h0;
    cpu_addr = 16'h5A5A;
    cpu_pc = 16'h0000;
    mode_pulse = 6'h00;
    cpu_exc_src = 5'h00;
  end

  // One access; the address shows garbage once released
  task automatic access(input logic we, input logic f, input logic [15:0] a,
                        input logic [15:0] pc);
    @(posedge clock);
    cpu_req <= 1'b1;
    cpu_we <= we;
    cpu_fetch <= f;
    cpu_addr <= a;
    cpu_pc <= pc;
    @(posedge clock);
    cpu_req <= 1'b0;
    cpu_we <= 1'b0;
    cpu_fetch <= 1'b0;
    cpu_addr <= ~a;
  endtask

  // One-cycle strobes of mode changes, exception sources, interrupt return
  task automatic strobe(input logic [5:0] m, input logic [4:0] s, input logic r);
    @(posedge clock);
    mode_pulse <= m;
    cpu_exc_src <= s;
    return_from_interrupt_instr_exec <= r;
    @(posedge clock);
    mode_pulse <= 6'h00;
    cpu_exc_src <= 5'h00;
    return_from_interrupt_instr_exec <= 1'b0;
  endtask
endmodule // cms_cpu_model

// ### testbench/testbench.sv
// Self-checking bench for the CPU mode and segment protection block.
// Assumes the checker and the CPU core model are compiled first.
`timescale 1ns/1ps
`include "cms_map.vh"

module testbench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] q;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, irq, cpu_req, cpu_we, cpu_fetch, return_from_interrupt_instr_exec;
  wire mem_req, mem_we, exc_take, nvm_rsvd_hit;
  wire [15:0] cpu_addr, cpu_pc, mem_phys, exc_vector;
  wire [5:0] mode_pulse;
  wire [4:0] cpu_exc_src;
  wire [1:0] mem_target;
  wire [2:0] cpu_mode;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  cms_cpu_model i_cpu (.clock(clock), .cpu_req(cpu_req), .cpu_we(cpu_we),
    .cpu_fetch(cpu_fetch), .cpu_addr(cpu_addr), .cpu_pc(cpu_pc), .mode_pulse(mode_pulse),
    .cpu_exc_src(cpu_exc_src), .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec));

  cms_mode_mmu i_dut (.clock(clock), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_fetch(cpu_fetch), .cpu_addr(cpu_addr),
    .cpu_pc(cpu_pc), .boot_done(mode_pulse[0]), .fw_enter(mode_pulse[1]),
    .fw_exit(mode_pulse[2]), .test_enter(mode_pulse[3]), .test_exit(mode_pulse[4]),
    .sys_to_user(mode_pulse[5]), .cpu_exc_src(cpu_exc_src), .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec),
    .mem_req(mem_req), .mem_target(mem_target), .mem_phys(mem_phys), .mem_we(mem_we),
    .exc_take(exc_take), .exc_vector(exc_vector), .cpu_mode(cpu_mode),
    .nvm_rsvd_hit(nvm_rsvd_hit));

  // Clock and cycle ceiling
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Avalon-MM access held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
    bus(1'b0, a, 32'h0000_0000);
    check(name, q, exp);
  endtask

  // A vector of zero means the access must pass
  task automatic acc(input logic we, input logic f, input logic [15:0] a,
                     input logic [15:0] pc, input logic [15:0] vec);
    i_cpu.access(we, f, a, pc);
    #1;
    check("mem_req", mem_req, vec == 16'h0000);
    check("exc_take", exc_take, vec != 16'h0000);
    check("mem_we", mem_we, we && vec == 16'h0000);
    if (vec != 16'h0000) check("exc_vector", exc_vector, vec);
    if (vec != 16'h0000) check("cpu_mode", cpu_mode, `CMS_MODE_SYS);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    rd(8'h00, 32'h0000_0000, "mode");
    rd(8'h04, 32'h0000_0000, "status");
    rd(8'h08, 32'h0000_0000, "mask");
    i_cpu.strobe(6'h08, 5'h00, 1'b0);
    rd(8'h00, 32'h0000_0001, "mode");
    i_cpu.strobe(6'h10, 5'h00, 1'b0);
    rd(8'h00, 32'h0000_0000, "mode");
    bus(1'b1, 8'h0C, `CMS_LOCK_KEY);
    rd(8'h0C, 32'h0000_0001, "lock");
    i_cpu.strobe(6'h08, 5'h00, 1'b0);
    rd(8'h00, 32'h0000_0000, "mode");
    i_cpu.strobe(6'h01, 5'h00, 1'b0);
    rd(8'h00, 32'h0000_0003, "mode");
    $display("test reset and lock done");
    for (int i = 0; i < 5; i++) begin
      i_cpu.strobe(6'h00, 5'h01 << i, 1'b0);
      #1;
      check("exc_take", exc_take, 1'b1);
      check("exc_vector", exc_vector, 16'h0100 + 16'(4 * i));
    end
    rd(8'h04, 32'h0000_001F, "status");
    $display("test exception sources done");
    // Segment 0: RAM read with group 0; segment 1: ROM execute only
    bus(1'b1, 8'h10, 32'h0000_0000);
    bus(1'b1, 8'h14, 32'h0000_0000);
    bus(1'b1, 8'h18, 32'h0000_0100);
    bus(1'b1, 8'h1C, 32'h0000_0103);
    rd(8'h1C, 32'h0000_0103, "seg_ctrl");
    bus(1'b1, 8'h10, 32'h0000_0001);
    bus(1'b1, 8'h14, 32'h0000_4000);
    bus(1'b1, 8'h18, 32'h0000_0100);
    bus(1'b1, 8'h1C, 32'h0000_0009);
    bus(1'b1, 8'h08, 32'h0000_0040);
    acc(1'b1, 1'b0, 16'h8000, 16'h0000, 16'h0000);
    check("mem_target", mem_target, 2'h2);
    acc(1'b0, 1'b0, 16'hEF00, 16'h0000, 16'h0000);
    $display("test system access done");
    i_cpu.strobe(6'h20, 5'h00, 1'b0);
    rd(8'h00, 32'h0000_0004, "mode");
    acc(1'b0, 1'b0, 16'h0010, 16'h4000, 16'h0000);
    check("mem_phys", mem_phys, 16'h0010);
    acc(1'b0, 1'b1, 16'h4010, 16'h4010, 16'h0000);
    check("mem_target", mem_target, 2'h1);
    acc(1'b0, 1'b0, 16'hF000, 16'h0010, 16'h0000);
    check("mem_target", mem_target, 2'h3);
    bus(1'b1, 8'h08, 32'h0000_00FF);
    acc(1'b1, 1'b0, 16'h0010, 16'h0010, 16'h0118);
    rd(8'h08, 32'h0000_0040, "mask");
    check("irq", irq, 1'b1);
    rd(8'h20, 32'h0000_0010, "fault");
    rd(8'h04, 32'h0000_0040, "status");
    #1;
    check("irq", irq, 1'b0);
    $display("test user rights done");
    i_cpu.strobe(6'h20, 5'h00, 1'b0);
    i_cpu.strobe(6'h00, 5'h00, 1'b1);
    #1;
    check("exc_vector", exc_vector, 16'h0114);
    i_cpu.strobe(6'h20, 5'h00, 1'b0);
    acc(1'b0, 1'b0, 16'hF010, 16'h0010, 16'h0118);
    i_cpu.strobe(6'h20, 5'h00, 1'b0);
    acc(1'b0, 1'b0, 16'hEF00, 16'h0010, 16'h0118);
    i_cpu.strobe(6'h20, 5'h00, 1'b0);
    acc(1'b0, 1'b0, 16'h9000, 16'h0010, 16'h0118);
    bus(1'b1, 8'h10, 32'h0000_0002);
    bus(1'b1, 8'h14, 32'h0000_0000);
    bus(1'b1, 8'h18, 32'h0000_0100);
    bus(1'b1, 8'h1C, 32'h0000_0005);
    i_cpu.strobe(6'h20, 5'h00, 1'b0);
    acc(1'b0, 1'b0, 16'h0010, 16'h0010, 16'h011C);
    $display("test traps done");
    @(posedge clock);
    reset <= 1'b1;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    #1;
    check("cpu_mode", cpu_mode, `CMS_MODE_BOOT);
    check("mem_req", mem_req, 1'b0);
    i_cpu.strobe(6'h08, 5'h00, 1'b0);
    rd(8'h00, 32'h0000_0000, "mode");
    rd(8'h0C, 32'h0000_0001, "lock");
    i_cpu.strobe(6'h01, 5'h00, 1'b0);
    i_cpu.strobe(6'h02, 5'h00, 1'b0);
    rd(8'h00, 32'h0000_0002, "mode");
    i_cpu.strobe(6'h04, 5'h00, 1'b0);
    rd(8'h00, 32'h0000_0003, "mode");
    $display("test second reset done");
    conclude();
  end
endmodule // testbench
